// ===== shared/strap_pkg.sv
// constants and types shared by the strap option loader
package strap_pkg;

  // strap pin positions inside the strap vector
  localparam int STRAP_COUNT   = 6;
  localparam int STRAP_PWR     = 0;  // energy-detect power-down strap
  localparam int STRAP_DRIVE   = 1;  // i/o drive strength strap
  localparam int STRAP_CLKMODE = 2;  // rmii_clock_mode_strap
  localparam int STRAP_ANEG    = 3;  // port 3 auto-negotiation strap
  localparam int STRAP_FLOW    = 4;  // port 3 flow-control strap
  localparam int STRAP_DUPLEX  = 5;  // port 3 fallback duplex strap

  // register addresses on the configuration write port
  localparam logic [7:0] ADDR_REG14  = 8'h0E;
  localparam logic [7:0] ADDR_REG132 = 8'h84;
  localparam logic [7:0] ADDR_REG60  = 8'h3C;
  localparam logic [7:0] ADDR_REG50  = 8'h32;

  // field positions
  localparam int ENERGY_DETECT_POWER_DOWN_LSB   = 3;
  localparam int DRIVE_LSB  = 6;
  localparam int ANEG_BIT   = 7;
  localparam int DUPLEX_BIT = 5;
  localparam int FLOW_BIT   = 4;

  // field encodings
  localparam logic [1:0] ENERGY_DETECT_POWER_DOWN_NORMAL = 2'h0;
  localparam logic [1:0] ENERGY_DETECT_POWER_DOWN_ON     = 2'h3;
  localparam logic [1:0] DRIVE_8MA   = 2'h0;
  localparam logic [1:0] DRIVE_12MA  = 2'h1;

  // register values after reset, strap defaults applied
  localparam logic [7:0] REG14_RESET  = 8'h00;
  localparam logic [7:0] REG132_RESET = 8'h00;
  localparam logic [7:0] REG60_RESET  = 8'hA0;
  localparam logic [7:0] REG50_RESET  = 8'h00;

  // serial_bus_config_select codes
  localparam logic [1:0] PS_EEPROM = 2'h0;
  localparam logic [1:0] PS_SMI    = 2'h1;
  localparam logic [1:0] PS_SPI    = 2'h2;
  localparam logic [1:0] PS_BIST   = 2'h3;

  // port 5 arrangement codes
  localparam logic [1:0] P5_INTEGRATED = 2'h0;
  localparam logic [1:0] P5_MAC_EXT    = 2'h1;
  localparam logic [1:0] P5_DUAL       = 2'h2;

  // loader sequence
  typedef enum logic [1:0] {ST_CAPTURE, ST_APPLY, ST_EEPROM, ST_RUN} load_state_t;

endpackage : strap_pkg

// ===== shared/strap_if.sv
// carrier between the loader sequencer and the strap pin capture
interface strap_if;
  import strap_pkg::*;

  logic                   captureStb;  // sample the strap pins at this edge
  logic                   driveEn;     // pins leave input mode and drive
  logic [STRAP_COUNT-1:0] strapLevel;  // captured strap levels

  modport ctrl (output captureStb, output driveEn, input strapLevel);
  modport cap  (input captureStb, input driveEn, output strapLevel);
endinterface : strap_if

// ===== src/strap_pin_capture.sv
// strap pin capture and dual-purpose pin drive
module strap_pin_capture (
  input  wire logic                             ref_clk,
  input  wire logic                             rst,
  input  wire logic                             clkEn,
  strap_if.cap                                  bus,
  input  wire logic [strap_pkg::STRAP_COUNT-1:0] pinIn,
  input  wire logic [strap_pkg::STRAP_COUNT-1:0] ledFunc,
  output logic      [strap_pkg::STRAP_COUNT-1:0] pinOut,
  output logic      [strap_pkg::STRAP_COUNT-1:0] pinOe
);
  import strap_pkg::*;

  typedef struct packed {
    logic [STRAP_COUNT-1:0] level;
    logic [STRAP_COUNT-1:0] outVal;
    logic                   drive;
  } capture_state_t;

  localparam capture_state_t CAP_RESET = '{level: '1, outVal: '0, drive: 1'b0};

  capture_state_t q;
  capture_state_t d;

  ////////////////////////////////////////////////////////////////////////
  // next state: levels caught once, led data followed afterwards
  always_comb begin
    d = q;
    if (bus.captureStb) begin
      d.level = pinIn;  // [R13]
    end
    d.drive  = bus.driveEn;
    d.outVal = bus.driveEn ? ledFunc : '0;
  end

  // state register, frozen while clkEn is low
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      q <= CAP_RESET;
    end else if (clkEn) begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // per-pin drive: input with pull during reset, led output afterwards
  genvar i;
  generate
    for (i = 0; i < STRAP_COUNT; i++) begin : gPin
      assign pinOut[i] = q.outVal[i];
      assign pinOe[i]  = q.drive;  // [R9]
    end
  endgenerate

  assign bus.strapLevel = q.level;

  ////////////////////////////////////////////////////////////////////////
  // checks
  a_pin_input_hold: assert property (@(posedge ref_clk) disable iff (rst)
    (!rst && clkEn && bus.captureStb) |=> (pinOe == '0) && (bus.strapLevel == $past(pinIn)))  // [R9]
    else $error("strap pins driven or level lost at capture");
  a_pin_drive_after: assert property (@(posedge ref_clk) disable iff (rst)
    (clkEn && bus.driveEn) |=> (pinOe == '1) && (pinOut == $past(ledFunc)))  // [R9]
    else $error("pins not driving led data after reset");

endmodule : strap_pin_capture

// ===== src/strap_option_loader.sv
// strap option loader: reset-time configuration from straps and serial bus pins
//
// Summary of operation
// [R1] power strap low sets energy-detect power-down
// [R2] drive strap picks 8mA or 12mA
// [R3] rmii clock strap picks crystal or external
// [R4] port 3 auto-negotiation strap into bit
// [R5] port 3 flow-control strap forces flow control
// [R6] port 3 duplex strap sets fallback duplex
// [R7] config pins select smi, spi or bist
// [R8] code 00 without eeprom starts on defaults
// [R9] strap pins input in reset, outputs after
// [R10] unmanaged configuration fixed only at reset time
// [R11] managed host reaches registers over spi/smi
// [R12] three port five arrangements supported
// [R13] straps captured once, kept until overwritten
module strap_option_loader #(
  parameter bit RMII_VARIANT = 1'b1
) (
  input  wire logic                              ref_clk,
  input  wire logic                              rst,
  input  wire logic                              clkEn,
  input  wire logic [strap_pkg::STRAP_COUNT-1:0] pinIn,
  input  wire logic [strap_pkg::STRAP_COUNT-1:0] ledFunc,
  output logic      [strap_pkg::STRAP_COUNT-1:0] pinOut,
  output logic      [strap_pkg::STRAP_COUNT-1:0] pinOe,
  input  wire logic [1:0]                        serialBusConfigSelect,
  input  wire logic [1:0]                        port5Select,
  input  wire logic                              eepromPresent,
  input  wire logic                              eepromDone,
  input  wire logic                              cfgWrEn,
  input  wire logic [7:0]                        cfgWrAddr,
  input  wire logic [7:0]                        cfgWrData,
  output logic      [7:0]                        ctrlReg14,
  output logic      [7:0]                        ctrlReg132,
  output logic      [7:0]                        port3Reg60,
  output logic      [7:0]                        port3Reg50,
  output logic                                   rmiiClockFromCrystal,
  output logic                                   rmiiRefClockOutEn,
  output logic                                   smiEnable,
  output logic                                   spiSlaveEnable,
  output logic                                   bistEnable,
  output logic                                   eepromLoadActive,
  output logic                                   configReady,
  output logic                                   mac5ExternalEn,
  output logic                                   phy5ExternalEn,
  output logic                                   phy5PowerDown
);
  import strap_pkg::*;

  // images and mode flags, all registered so the outputs never glitch
  typedef struct packed {
    load_state_t fsm;
    logic [1:0]  psSel;
    logic [1:0]  p5Sel;
    logic [7:0]  reg14;
    logic [7:0]  reg132;
    logic [7:0]  reg60;
    logic [7:0]  reg50;
    logic        clkXtal;
    logic        refOutEn;
    logic        smi;
    logic        spi;
    logic        bist;
    logic        eeLoad;
    logic        ready;
    logic        mac5Ext;
    logic        phy5Ext;
    logic        phy5Pd;
    logic        drive;
  } loader_state_t;

  localparam loader_state_t LOADER_RESET = '{
    fsm: ST_CAPTURE, psSel: PS_EEPROM, p5Sel: P5_INTEGRATED,
    reg14: REG14_RESET, reg132: REG132_RESET, reg60: REG60_RESET, reg50: REG50_RESET,
    clkXtal: 1'b1, refOutEn: 1'b0, smi: 1'b0, spi: 1'b0, bist: 1'b0, eeLoad: 1'b0,
    ready: 1'b0, mac5Ext: 1'b0, phy5Ext: 1'b0, phy5Pd: 1'b0, drive: 1'b0};

  loader_state_t q;
  loader_state_t d;
  logic          wrOk;
  logic          needEeprom;

  strap_if pins ();

  ////////////////////////////////////////////////////////////////////////
  // strap pin capture and led drive
  strap_pin_capture uCapture (
    .ref_clk (ref_clk),
    .rst     (rst),
    .clkEn   (clkEn),
    .bus     (pins.cap),
    .pinIn   (pinIn),
    .ledFunc (ledFunc),
    .pinOut  (pinOut),
    .pinOe   (pinOe)
  );

  // capture strobe only in the first state after reset release
  // reset overrides the strobe, so the first enabled edge after release samples
  assign pins.captureStb = (q.fsm == ST_CAPTURE);  // [R13]
  assign pins.driveEn    = q.drive;                // [R9]

  ////////////////////////////////////////////////////////////////////////
  // write acceptance: eeprom load window, or a managed host afterwards
  // writes during capture and apply are dropped so a strap value is never half applied
  always_comb begin
    needEeprom = (q.psSel == PS_EEPROM) && eepromPresent;
    wrOk       = 1'b0;
    if (q.fsm == ST_EEPROM) begin
      wrOk = cfgWrEn;  // [R10]
    end else if (q.fsm == ST_RUN) begin
      wrOk = cfgWrEn && (q.smi || q.spi);  // [R11]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // sequencer and register images
  always_comb begin
    d = q;
    case (q.fsm)
      ST_CAPTURE: begin
        d.psSel = serialBusConfigSelect;  // [R10]
        d.p5Sel = port5Select;
        d.fsm   = ST_APPLY;
      end
      ST_APPLY: begin
        // levels already registered one edge earlier, so pin noise cannot reach here
        d.reg14[ENERGY_DETECT_POWER_DOWN_LSB +: 2] = pins.strapLevel[STRAP_PWR] ? ENERGY_DETECT_POWER_DOWN_NORMAL : ENERGY_DETECT_POWER_DOWN_ON;       // [R1]
        d.reg132[DRIVE_LSB +: 2] = pins.strapLevel[STRAP_DRIVE] ? DRIVE_8MA : DRIVE_12MA;  // [R2]
        d.clkXtal  = RMII_VARIANT ? pins.strapLevel[STRAP_CLKMODE] : 1'b1;                 // [R3]
        d.refOutEn = RMII_VARIANT && pins.strapLevel[STRAP_CLKMODE];                       // [R3]
        d.reg60[ANEG_BIT]   = pins.strapLevel[STRAP_ANEG];    // [R4]
        d.reg50[FLOW_BIT]   = ~pins.strapLevel[STRAP_FLOW];   // [R5]
        d.reg60[DUPLEX_BIT] = pins.strapLevel[STRAP_DUPLEX];  // [R6]
        // management interface from the serial bus configuration code
        d.smi  = (q.psSel == PS_SMI);   // [R7]
        d.spi  = (q.psSel == PS_SPI);   // [R7]
        d.bist = (q.psSel == PS_BIST);  // [R7]
        // port five arrangement
        d.mac5Ext = (q.p5Sel == P5_MAC_EXT) || (q.p5Sel == P5_DUAL);  // [R12]
        d.phy5Ext = (q.p5Sel == P5_DUAL);                             // [R12]
        d.phy5Pd  = (q.p5Sel == P5_MAC_EXT);                          // [R12]
        d.drive   = 1'b1;  // [R9]
        d.eeLoad  = needEeprom;
        d.ready   = !needEeprom;  // [R8]
        d.fsm     = needEeprom ? ST_EEPROM : ST_RUN;  // [R8]
      end
      ST_EEPROM: begin
        // no timeout: a missing done keeps the device waiting, like a stuck eeprom
        if (eepromDone) begin
          d.eeLoad = 1'b0;
          d.ready  = 1'b1;
          d.fsm    = ST_RUN;
        end
      end
      default: begin
        // run state is final until the next reset
        d.fsm = ST_RUN;
      end
    endcase
    // overwrite of captured values by eeprom or host
    // writes to other addresses are dropped without any sign
    if (wrOk) begin
      if (cfgWrAddr == ADDR_REG14) begin
        d.reg14 = cfgWrData;  // [R13]
      end else if (cfgWrAddr == ADDR_REG132) begin
        d.reg132 = cfgWrData;
      end else if (cfgWrAddr == ADDR_REG60) begin
        d.reg60 = cfgWrData;
      end else if (cfgWrAddr == ADDR_REG50) begin
        d.reg50 = cfgWrData;
      end
    end
  end

  // state register, frozen while clkEn is low
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      q <= LOADER_RESET;
    end else if (clkEn) begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs straight from the state register
  // no logic after the register, so strap results hold steady for the fabric
  assign ctrlReg14            = q.reg14;
  assign ctrlReg132           = q.reg132;
  assign port3Reg60           = q.reg60;
  assign port3Reg50           = q.reg50;
  assign rmiiClockFromCrystal = q.clkXtal;
  assign rmiiRefClockOutEn    = q.refOutEn;
  assign smiEnable            = q.smi;
  assign spiSlaveEnable       = q.spi;
  assign bistEnable           = q.bist;
  assign eepromLoadActive     = q.eeLoad;
  assign configReady          = q.ready;
  assign mac5ExternalEn       = q.mac5Ext;
  assign phy5ExternalEn       = q.phy5Ext;
  assign phy5PowerDown        = q.phy5Pd;

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  sequence applyEdge;
    clkEn && (q.fsm == ST_APPLY);
  endsequence

  // strap fields land one edge after apply
  a_energy_detect_power_down_field: assert property (applyEdge |=>  // [R1]
    ctrlReg14[4:3] == ($past(pins.strapLevel[STRAP_PWR]) ? ENERGY_DETECT_POWER_DOWN_NORMAL : ENERGY_DETECT_POWER_DOWN_ON))
    else $error("power-down field does not follow strap");
  a_drive_field: assert property (applyEdge |=>  // [R2]
    ctrlReg132[7:6] == ($past(pins.strapLevel[STRAP_DRIVE]) ? DRIVE_8MA : DRIVE_12MA))
    else $error("drive strength field does not follow strap");
  a_clock_mode: assert property (applyEdge |=>  // [R3]
    (rmiiRefClockOutEn == (RMII_VARIANT && $past(pins.strapLevel[STRAP_CLKMODE])))
    && (rmiiRefClockOutEn == rmiiClockFromCrystal || !RMII_VARIANT))
    else $error("rmii clock source does not follow strap");
  a_aneg_bit: assert property (applyEdge |=>  // [R4]
    port3Reg60[7] == $past(pins.strapLevel[STRAP_ANEG]))
    else $error("auto-negotiation bit does not follow strap");
  a_flow_bit: assert property (applyEdge |=>  // [R5]
    port3Reg50[4] == !$past(pins.strapLevel[STRAP_FLOW]))
    else $error("flow-control bit does not follow strap");
  a_duplex_bit: assert property (applyEdge |=>  // [R6]
    port3Reg60[5] == $past(pins.strapLevel[STRAP_DUPLEX]))
    else $error("duplex bit does not follow strap");

  // mode decode and ready
  a_mgmt_decode: assert property (applyEdge |=>  // [R7]
    ({smiEnable, spiSlaveEnable, bistEnable} ==
     {$past(q.psSel) == PS_SMI, $past(q.psSel) == PS_SPI, $past(q.psSel) == PS_BIST}))
    else $error("management mode decode wrong");
  a_no_eeprom_wait: assert property ((applyEdge and !needEeprom) |=>  // [R8]
    configReady && !eepromLoadActive && (q.fsm == ST_RUN))
    else $error("device waited for eeprom without one");

  // lock after the load, host access when managed
  a_unmanaged_lock: assert property (  // [R10]
    (q.fsm == ST_RUN && !smiEnable && !spiSlaveEnable) |=>
    $stable({ctrlReg14, ctrlReg132, port3Reg60, port3Reg50}))
    else $error("unmanaged configuration changed after reset");
  a_host_write: assert property (  // [R11]
    (clkEn && q.fsm == ST_RUN && cfgWrEn && spiSlaveEnable && cfgWrAddr == ADDR_REG60) |=>
    port3Reg60 == $past(cfgWrData))
    else $error("managed host write not taken");
  a_port5_decode: assert property (applyEdge |=>  // [R12]
    (phy5ExternalEn -> mac5ExternalEn) && !(phy5ExternalEn && phy5PowerDown))
    else $error("port five arrangement inconsistent");
  a_capture_once: assert property ((q.fsm != ST_CAPTURE) |=>  // [R13]
    (q.fsm != ST_CAPTURE) && $stable(pins.strapLevel))
    else $error("straps sampled again after reset");

  // no image change while sampling, no state change while frozen
  a_capture_quiet: assert property ((q.fsm == ST_CAPTURE) |=>  // [R10]
    $stable({ctrlReg14, ctrlReg132, port3Reg60, port3Reg50}))
    else $error("register image changed while straps were sampled");
  a_ready_no_early: assert property ((q.fsm == ST_CAPTURE) |=> !configReady)  // [R8]
    else $error("configuration ready before the straps were applied");
  a_clock_freeze: assert property (!clkEn |=> $stable(q))  // [R13]
    else $error("state moved while clock enable was low");

  // eeprom load window: writes land, then done closes it
  a_eeprom_write: assert property (  // [R10]
    (clkEn && q.fsm == ST_EEPROM && cfgWrEn && cfgWrAddr == ADDR_REG50) |=>
    port3Reg50 == $past(cfgWrData))
    else $error("eeprom write not taken during load");
  a_eeprom_wait: assert property ((applyEdge and needEeprom) |=>  // [R8]
    !configReady && eepromLoadActive && (q.fsm == ST_EEPROM))
    else $error("eeprom load window not opened");
  a_eeprom_end: assert property (  // [R10]
    (clkEn && q.fsm == ST_EEPROM && eepromDone) |=>
    configReady && !eepromLoadActive && (q.fsm == ST_RUN))
    else $error("eeprom load did not end on done");
  a_ready_hold: assert property (configReady |=> configReady)  // [R10]
    else $error("configuration ready dropped without reset");

  // managed host over the serial management interface
  a_host_smi: assert property (  // [R11]
    (clkEn && q.fsm == ST_RUN && cfgWrEn && smiEnable && cfgWrAddr == ADDR_REG14) |=>
    ctrlReg14 == $past(cfgWrData))
    else $error("management interface write not taken");

  // pin direction and exact port five decode
  a_pins_input: assert property ((q.fsm inside {ST_CAPTURE, ST_APPLY}) |-> (pinOe == '0))  // [R9]
    else $error("strap pins driven before the load finished");
  a_port5_exact: assert property (applyEdge |=>  // [R12]
    ({mac5ExternalEn, phy5ExternalEn, phy5PowerDown} ==
     {$past(q.p5Sel) == P5_MAC_EXT || $past(q.p5Sel) == P5_DUAL,
      $past(q.p5Sel) == P5_DUAL, $past(q.p5Sel) == P5_MAC_EXT}))
    else $error("port five arrangement does not follow select");

  // main scenarios
  c_eeprom_load: cover property (clkEn && q.fsm == ST_EEPROM && eepromDone);
  c_spi_managed: cover property (q.fsm == ST_RUN && spiSlaveEnable && cfgWrEn);
  c_energy_detect_power_down_strap:  cover property (applyEdge and !pins.strapLevel[STRAP_PWR]);
  c_dual_port5:  cover property (phy5ExternalEn);
  c_host_refused: cover property (q.fsm == ST_RUN && cfgWrEn && !smiEnable && !spiSlaveEnable);

endmodule : strap_option_loader

// ===== verification/strap_partner.sv
// strap resistor and configuration eeprom model facing the loader pins
module strap_partner #(
  parameter logic [7:0] EE_BYTE = 8'h5A
) (
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic [5:0] strapLevel,
  input  wire logic       fitted,
  input  wire logic       slow,
  input  wire logic [5:0] pinOe,
  input  wire logic [5:0] pinOut,
  output logic      [5:0] pinIn,
  output logic            eepromPresent,
  input  wire logic       eepromLoadActive,
  output logic            eepromDone,
  output logic            eeWrEn,
  output logic      [7:0] eeWrData
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] cnt;
  // resistor level while the pin is an input, the loader's drive after
  assign pinIn = (pinOe & pinOut) | (~pinOe & strapLevel);
  assign eepromPresent = fitted;
  assign eeWrData = EE_BYTE;
  // reset-time load: one byte written, then done, fast or slow
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cnt <= 5'h00;
      eeWrEn <= 1'b0;
      eepromDone <= 1'b0;
    end else begin
      eeWrEn <= 1'b0;
      if (!eepromLoadActive) begin
        cnt <= 5'h00;
        eepromDone <= 1'b0;
      end else if (!eepromDone) begin
        cnt <= cnt + 5'h01;
        if (cnt == (slow ? 5'h14 : 5'h01)) eeWrEn <= 1'b1;
        if (cnt == (slow ? 5'h15 : 5'h02)) eepromDone <= 1'b1;
      end
    end
  end
endmodule : strap_partner

// ===== verification/test_strap_option_loader.sv
// self-checking bench for the strap option loader
module test_strap_option_loader;
  timeunit 1ns;
  timeprecision 1ps;
  import strap_pkg::*;
  typedef struct packed {
    logic [7:0] r14, r132, r60, r50;
    logic [9:0] fl;
    logic [5:0] oe, po;
  } exp_t;
  localparam logic [7:0] EE_BYTE = 8'h5A;
  logic       ref_clk = 0, rst = 1, clkEn = 1, fitted = 0, slow = 0, hostEn = 0, chkStb = 0;
  logic [5:0] strap = 0, led = 0, pinIn, pinOut, pinOe;
  logic [1:0] sbSel = 0, p5Sel = 0;
  logic [7:0] hostAddr = 0, hostData = 0, eeWrData, cfgWrAddr, cfgWrData;
  logic [7:0] ctrlReg14, ctrlReg132, port3Reg60, port3Reg50;
  logic       eepromPresent, eepromDone, eeWrEn, cfgWrEn, xtal, refOut, smi, spi, bist, eeLoad, configReady;
  logic       mac5, phy5, phy5Pd;
  int         seed = 32'h812a;
  int         err_total = 0;
  int         cmp_count = 0;
  exp_t       expQ[$];
  // host writes share the port with the eeprom model
  assign cfgWrEn = hostEn | eeWrEn;
  assign cfgWrAddr = eeWrEn ? ADDR_REG50 : hostAddr;
  assign cfgWrData = eeWrEn ? eeWrData : hostData;
  always #2.5 ref_clk = ~ref_clk;
  strap_option_loader uut (.ref_clk(ref_clk), .rst(rst), .clkEn(clkEn), .pinIn(pinIn), .ledFunc(led),
    .pinOut(pinOut), .pinOe(pinOe), .serialBusConfigSelect(sbSel), .port5Select(p5Sel),
    .eepromPresent(eepromPresent), .eepromDone(eepromDone), .cfgWrEn(cfgWrEn), .cfgWrAddr(cfgWrAddr),
    .cfgWrData(cfgWrData), .ctrlReg14(ctrlReg14), .ctrlReg132(ctrlReg132), .port3Reg60(port3Reg60),
    .port3Reg50(port3Reg50), .rmiiClockFromCrystal(xtal), .rmiiRefClockOutEn(refOut), .smiEnable(smi),
    .spiSlaveEnable(spi), .bistEnable(bist), .eepromLoadActive(eeLoad), .configReady(configReady),
    .mac5ExternalEn(mac5), .phy5ExternalEn(phy5), .phy5PowerDown(phy5Pd));
  strap_partner #(.EE_BYTE(EE_BYTE)) far (.ref_clk(ref_clk), .rst(rst), .strapLevel(strap), .fitted(fitted),
    .slow(slow), .pinOe(pinOe), .pinOut(pinOut), .pinIn(pinIn), .eepromPresent(eepromPresent),
    .eepromLoadActive(eeLoad), .eepromDone(eepromDone), .eeWrEn(eeWrEn), .eeWrData(eeWrData));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : stop_test
  // byte-wide register image compare
  task automatic chk_reg(string n, logic [7:0] e, logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : chk_reg
  // level vector compare
  task automatic chk_lvl(string n, logic [15:0] e, logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : chk_lvl
  // expected image after the strap load
  function automatic exp_t calc(logic [5:0] s, logic [1:0] m, logic f, logic [1:0] p, logic [5:0] l);
    exp_t e;
    e.r14 = s[STRAP_PWR] ? 8'h00 : {3'h0, ENERGY_DETECT_POWER_DOWN_ON, 3'h0};
    e.r132 = {s[STRAP_DRIVE] ? DRIVE_8MA : DRIVE_12MA, 6'h00};
    e.r60 = {s[STRAP_ANEG], 1'b0, s[STRAP_DUPLEX], 5'h00};
    e.r50 = (m == PS_EEPROM && f) ? EE_BYTE : {3'h0, ~s[STRAP_FLOW], 4'h0};
    e.fl = {s[STRAP_CLKMODE], s[STRAP_CLKMODE], m == PS_SMI, m == PS_SPI, m == PS_BIST, 1'b0, 1'b1,
            p == P5_MAC_EXT || p == P5_DUAL, p == P5_DUAL, p == P5_MAC_EXT};
    e.oe = 6'h3F;
    e.po = l;
    return e;
  endfunction : calc
  // queue a note, flag it for the watcher at the next edge
  task automatic note(exp_t e);
    expQ.push_back(e);
    chkStb <= 1'b1;
    @(posedge ref_clk);
    chkStb <= 1'b0;
  endtask : note
  // bounded wait for the end of the load
  task automatic wait_ready();
    int k;
    for (k = 0; k < 100 && configReady !== 1'b1; k++) @(posedge ref_clk);
    if (k == 100) begin
      err_total++;
      stop_test();
    end
  endtask : wait_ready
  // watcher: oldest note against the outputs
  always @(posedge ref_clk) begin
    exp_t e;
    if (chkStb) begin
      e = expQ.pop_front();
      chk_reg("reg14", e.r14, ctrlReg14);
      chk_reg("reg132", e.r132, ctrlReg132);
      chk_reg("reg60", e.r60, port3Reg60);
      chk_reg("reg50", e.r50, port3Reg50);
      chk_lvl("modes", {6'h00, e.fl},
              {6'h00, xtal, refOut, smi, spi, bist, eeLoad, configReady, mac5, phy5, phy5Pd});
      chk_lvl("pinOe", {10'h000, e.oe}, {10'h000, pinOe});
      chk_lvl("pinOut", {10'h000, e.po}, {10'h000, pinOut});
    end
  end
  // every config code, random straps, fast and slow eeprom, then host writes
  initial begin
    logic [31:0] r;
    exp_t        e;
    for (int i = 0; i < 12; i++) begin
      r = $random(seed);
      @(posedge ref_clk);
      rst <= 1'b1;
      {slow, fitted, p5Sel, led, strap} <= r[15:0];
      sbSel <= i[1:0];
      repeat (12) @(posedge ref_clk);
      note('{REG14_RESET, REG132_RESET, REG60_RESET, REG50_RESET, 10'h200, 6'h00, 6'h00});
      rst <= 1'b0;
      wait_ready();
      repeat (2) @(posedge ref_clk);
      e = calc(strap, sbSel, fitted, p5Sel, led);
      note(e);
      hostEn <= 1'b1;
      hostAddr <= ADDR_REG60;
      hostData <= r[23:16];
      strap <= ~strap;
      led <= ~led;
      @(posedge ref_clk);
      clkEn <= 1'b0;
      hostAddr <= ADDR_REG132;
      hostData <= ~r[23:16];
      @(posedge ref_clk);
      clkEn <= 1'b1;
      hostAddr <= 8'h00;
      @(posedge ref_clk);
      hostAddr <= ADDR_REG14;
      hostData <= r[31:24];
      @(posedge ref_clk);
      hostEn <= 1'b0;
      repeat (2) @(posedge ref_clk);
      e.po = led;
      if (sbSel == PS_SMI || sbSel == PS_SPI) begin
        e.r60 = r[23:16];
        e.r14 = r[31:24];
      end
      note(e);
    end
    stop_test();
  end
endmodule : test_strap_option_loader
